// file: rtl/dcm_mode_ctrl.sv
// Channel mode control decode: DAC scale, power-down, profile modulation
//
// What this block does
// - Two-bit field scales each DAC full-scale current
// - Channel power-down bits act only with pin low
// - Pin high, mode 0: digital and DAC logic down
// - Pin high, mode 1: everything down, PLL included
// - Pin high ignores channel and clock power-down bits
// - Power-down signals: one means low power
// - Bypassed PLL is always shut down
// - Sixteen words per channel at documented indices
// - Word widths; phase and amplitude taken MSB aligned
// - Per-channel field picks modulation type
// - Global field picks two to sixteen levels
// - Ramp field picks ramp control source
// - Spare data lines as ramp inputs; single-bit port
// - Spare data lines never select channel words
// - Ramp pin low ramps up, high ramps down
// - Ramping with any modulation type except amplitude
// - Pin config field routes pins to channels
// - Two-level no-ramp: pin n drives channel n
// - Two-level frequency: pin low base, high profile one
// - Four levels: pin pairs select two channels' words
// - Eight levels: pins zero to two select word
// - Sixteen levels: pins zero to three select word
`timescale 1ns/1ps
`default_nettype none

module dcm_mode_ctrl
	import dcm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] profile_pin,
	input wire logic [2:0] spare_sdio,
	input wire logic external_powerdown_pin,
	output logic [CH_N-1:0][FREQ_W-1:0] freq_word,
	output logic [CH_N-1:0][PHASE_W-1:0] phase_word,
	output logic [CH_N-1:0][AMP_W-1:0] amp_word,
	output logic [CH_N-1:0][1:0] dac_atten,
	output logic [CH_N-1:0] chan_digital_pd,
	output logic [CH_N-1:0] chan_dac_pd,
	output logic dac_bias_pd,
	output logic pll_pd,
	output logic osc_pd,
	output logic clk_input_pd,
	output logic [CH_N-1:0] amplitude_ramp_active,
	output logic [CH_N-1:0] amplitude_ramp_down,
	output logic serial_single_bit
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [3:0] prof_meta_ff;
	logic [3:0] prof_sync_ff;
	logic [2:0] sdio_meta_ff;
	logic [2:0] sdio_sync_ff;
	logic pd_meta_ff;
	logic pd_sync_ff;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			prof_meta_ff <= 4'h0;
			prof_sync_ff <= 4'h0;
			sdio_meta_ff <= 3'h0;
			sdio_sync_ff <= 3'h0;
			pd_meta_ff <= 1'b0;
			pd_sync_ff <= 1'b0;
		end
		else
		begin
			prof_meta_ff <= profile_pin;
			prof_sync_ff <= prof_meta_ff;
			sdio_meta_ff <= spare_sdio;
			sdio_sync_ff <= sdio_meta_ff;
			pd_meta_ff <= external_powerdown_pin;
			pd_sync_ff <= pd_meta_ff;
		end
	end

	a_pin_sync_delay: assert property (
		!$past(rst) && !$past(rst, 2)
		|-> prof_sync_ff == $past(profile_pin, 2))
		else $error("profile pins not synchronised in two cycles");

	////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle per access
	logic ack_ff;
	logic [31:0] readdata_ff;
	logic [31:0] fr1_ff;
	logic [31:0] cfr_ff [CH_N];
	logic [FREQ_W-1:0] base_freq_ff [CH_N];
	logic [PHASE_W-1:0] base_phase_ff [CH_N];
	logic [AMP_W-1:0] base_amp_ff [CH_N];
	logic [31:0] prof_mem [CH_N*16];
	wire logic [6:0] route_w [CH_N];
	wire logic [CH_N-1:0] sweep_clash;

	wire logic req = avs_read | avs_write;
	wire logic nxt_ack = req & ~ack_ff;
	wire logic wr_go = avs_write & ack_ff;
	wire logic [1:0] a_ch = avs_address[9:8];
	wire logic [5:0] a_idx = avs_address[7:2];
	wire logic glob = (a_ch == 2'h0);
	wire logic hit_fr1 = glob && (a_idx == FR1_IDX);
	wire logic hit_stat = glob && (a_idx == STATUS_IDX);
	wire logic hit_sel = (a_idx == SEL_IDX);
	wire logic hit_cfr = (a_idx == CFR_IDX);
	wire logic hit_f0 = (a_idx == FREQ0_IDX);
	wire logic hit_p0 = (a_idx == PHASE0_IDX);
	wire logic hit_a0 = (a_idx == AMP0_IDX);
	wire logic hit_prof = (a_idx >= PROF_FIRST_IDX) &&
		(a_idx <= PROF_LAST_IDX);
	wire logic [5:0] slot6 = a_idx - PROF_SLOT_BASE;
	wire logic [5:0] mem_addr = {a_ch, slot6[3:0]};
	wire logic [31:0] be_mask = {{8{avs_byteenable[3]}},
		{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
		{8{avs_byteenable[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Power-down decode
	wire logic [1:0] level = fr1_ff[FR1_LEVEL_LSB +: 2];
	wire logic [1:0] ramp_src = fr1_ff[FR1_RAMP_LSB +: 2];
	wire logic [2:0] pin_to_channel_config = fr1_ff[FR1_PPC_LSB +: 3];
	wire logic [4:0] pll_mult = fr1_ff[FR1_MULT_LSB +: 5];
	wire logic pll_bypass = (pll_mult < PLL_MULT_MIN) ||
		(pll_mult > PLL_MULT_MAX);
	wire logic full_pd = pd_sync_ff & fr1_ff[FR1_PDMODE_BIT];
	wire logic nxt_pll_pd = pll_bypass | full_pd;
	wire logic nxt_clk_in_pd = pd_sync_ff ? full_pd :
		fr1_ff[FR1_CLKPD_BIT];

	wire logic [31:0] status_w = {12'h000, |sweep_clash,
		ramp_src == RAMP_SDIO, full_pd, pll_pd, chan_dac_pd,
		chan_digital_pd, pd_sync_ff, sdio_sync_ff, prof_sync_ff};
	wire logic [31:0] rd_mux =
		hit_fr1 ? fr1_ff :
		hit_stat ? status_w :
		hit_sel ? {25'h0, route_w[a_ch]} :
		hit_cfr ? cfr_ff[a_ch] :
		hit_f0 ? base_freq_ff[a_ch] :
		hit_p0 ? {18'h0, base_phase_ff[a_ch]} :
		hit_a0 ? {22'h0, base_amp_ff[a_ch]} :
		hit_prof ? prof_mem[mem_addr] : 32'h0;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack_ff <= 1'b0;
			readdata_ff <= 32'h0;
		end
		else
		begin
			ack_ff <= nxt_ack;
			if (nxt_ack)
				readdata_ff <= rd_mux;
		end
	end

	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata = readdata_ff;

	a_bus_one_wait: assert property (
		req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus access held more than one wait cycle");

	always_ff @(posedge clk)
	begin
		if (rst)
			fr1_ff <= FR1_RST;
		else if (wr_go && hit_fr1)
			fr1_ff <= merge(fr1_ff, avs_writedata, be_mask);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < CH_N*16; i++)
				prof_mem[i] <= 32'h0;
		end
		else if (wr_go && hit_prof)
			prof_mem[mem_addr] <= merge(prof_mem[mem_addr],
				avs_writedata, be_mask);
	end

	////////////////////////////////////////////////////////////////////
	// Pin routing per channel: {modulated, word index, ramp, ramp down}
	function automatic logic [6:0] route(input logic [1:0] ch,
		input logic [1:0] lvl, input logic [1:0] rmp,
		input logic [2:0] cfg, input logic [3:0] p,
		input logic [2:0] sd);
		logic [1:0] cha;
		logic [1:0] chb;
		logic pair_ok;
		logic [3:0] sdx;
		logic [6:0] r;
		r = 7'h00;
		pair_ok = 1'b1;
		sdx = {1'b0, sd};
		cha = 2'h0;
		chb = 2'h0;
		case (cfg)
			3'h0: begin cha = 2'h0; chb = 2'h1; end
			3'h1: begin cha = 2'h0; chb = 2'h2; end
			3'h2: begin cha = 2'h0; chb = 2'h3; end
			3'h3: begin cha = 2'h1; chb = 2'h2; end
			3'h4: begin cha = 2'h1; chb = 2'h3; end
			3'h5: begin cha = 2'h2; chb = 2'h3; end
			default: pair_ok = 1'b0;
		endcase
		case (lvl)
			LVL_2:
			begin
				if (rmp == RAMP_OFF)
					r = {1'b1, 3'h0, p[ch], 2'h0};
				else if (rmp == RAMP_SDIO)
					r = {1'b1, 3'h0, p[ch], ch != 2'h3, sdx[ch]};
				else if (rmp == RAMP_P2P3 && pair_ok && ch == cha)
					r = {1'b1, 3'h0, p[0], 1'b1, p[2]};
				else if (rmp == RAMP_P2P3 && pair_ok && ch == chb)
					r = {1'b1, 3'h0, p[1], 1'b1, p[3]};
			end
			LVL_4:
			begin
				if (pair_ok && (rmp == RAMP_OFF || rmp == RAMP_SDIO))
				begin
					if (ch == cha)
						r = {1'b1, 2'h0, p[0], p[1],
							rmp == RAMP_SDIO, sd[0]};
					else if (ch == chb)
						r = {1'b1, 2'h0, p[2], p[3],
							rmp == RAMP_SDIO, sd[1]};
				end
			end
			LVL_8:
			begin
				if (ch == cfg[1:0] &&
					(rmp == RAMP_OFF || rmp == RAMP_P3))
					r = {1'b1, 1'b0, p[0], p[1], p[2],
						rmp == RAMP_P3, p[3]};
			end
			LVL_16:
			begin
				if (ch == cfg[1:0] &&
					(rmp == RAMP_OFF || rmp == RAMP_SDIO))
					r = {1'b1, p[0], p[1], p[2], p[3],
						rmp == RAMP_SDIO, sd[0]};
			end
			default: r = 7'h00;
		endcase
		route = r;
	endfunction

	function automatic logic [1:0] atten(input logic [1:0] sc);
		case (sc)
			SCALE_FULL: atten = 2'h0;
			SCALE_HALF: atten = 2'h1;
			SCALE_QUARTER: atten = 2'h2;
			default: atten = 2'h3;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Per-channel registers, word selection and power-down
	for (genvar c = 0; c < CH_N; c++)
	begin : g_ch
		wire logic [1:0] mtype = cfr_ff[c][CFR_TYPE_LSB +: 2];
		wire logic [6:0] rt = route(2'(c), level, ramp_src, pin_to_channel_config,
			prof_sync_ff, sdio_sync_ff);
		wire logic modulated = rt[6] && (mtype != MOD_OFF);
		wire logic [3:0] widx = modulated ? rt[5:2] : 4'h0;
		wire logic ramp_ok = rt[1] && (mtype != MOD_AMP);
		wire logic [31:0] pword = prof_mem[{2'(c), widx}];
		wire logic use_prof = (widx != 4'h0);
		wire logic ch_wr = wr_go && (a_ch == 2'(c));

		assign route_w[c] = {modulated, widx, ramp_ok, rt[0]};
		assign sweep_clash[c] = modulated && cfr_ff[c][CFR_SWEEP_BIT];

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				cfr_ff[c] <= CFR_RST;
				base_freq_ff[c] <= '0;
				base_phase_ff[c] <= '0;
				base_amp_ff[c] <= '0;
			end
			else if (ch_wr)
			begin
				if (hit_cfr)
					cfr_ff[c] <= merge(cfr_ff[c], avs_writedata, be_mask);
				if (hit_f0)
					base_freq_ff[c] <= merge(base_freq_ff[c],
						avs_writedata, be_mask);
				if (hit_p0)
					base_phase_ff[c] <= PHASE_W'(merge(32'(base_phase_ff[c]),
						avs_writedata, be_mask));
				if (hit_a0)
					base_amp_ff[c] <= AMP_W'(merge(32'(base_amp_ff[c]),
						avs_writedata, be_mask));
			end
		end

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				freq_word[c] <= '0;
				phase_word[c] <= '0;
				amp_word[c] <= '0;
				dac_atten[c] <= 2'h0;
				chan_digital_pd[c] <= 1'b0;
				chan_dac_pd[c] <= 1'b0;
				amplitude_ramp_active[c] <= 1'b0;
				amplitude_ramp_down[c] <= 1'b0;
			end
			else
			begin
				freq_word[c] <= (mtype == MOD_FREQ && use_prof) ?
					pword : base_freq_ff[c];
				phase_word[c] <= (mtype == MOD_PHASE && use_prof) ?
					pword[31 -: PHASE_W] : base_phase_ff[c];
				amp_word[c] <= (mtype == MOD_AMP && use_prof) ?
					pword[31 -: AMP_W] : base_amp_ff[c];
				dac_atten[c] <= atten(cfr_ff[c][CFR_SCALE_LSB +: 2]);
				chan_digital_pd[c] <= pd_sync_ff |
					cfr_ff[c][CFR_DIGPD_BIT];
				chan_dac_pd[c] <= pd_sync_ff |
					cfr_ff[c][CFR_DACPD_BIT];
				amplitude_ramp_active[c] <= ramp_ok;
				amplitude_ramp_down[c] <= ramp_ok & rt[0];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dac_bias_pd <= 1'b0;
			pll_pd <= 1'b0;
			osc_pd <= 1'b0;
			clk_input_pd <= 1'b0;
			serial_single_bit <= 1'b0;
		end
		else
		begin
			dac_bias_pd <= full_pd;
			pll_pd <= nxt_pll_pd;
			osc_pd <= full_pd;
			clk_input_pd <= nxt_clk_in_pd;
			serial_single_bit <= (ramp_src == RAMP_SDIO);
		end
	end

	a_dac_scale_map: assert property (
		cfr_ff[0][CFR_SCALE_LSB +: 2] == SCALE_QUARTER
		|=> dac_atten[0] == 2'h2)
		else $error("quarter scale code not mapped to shift two");

	a_soft_pd_chan: assert property (
		!pd_sync_ff && !cfr_ff[1][CFR_DIGPD_BIT]
		|=> !chan_digital_pd[1])
		else $error("channel powered down without request");

	a_fast_pd_mode: assert property (
		pd_sync_ff && !fr1_ff[FR1_PDMODE_BIT] && !pll_bypass
		|=> (&chan_digital_pd) && (&chan_dac_pd) && !pll_pd
			&& !dac_bias_pd && !osc_pd && !clk_input_pd)
		else $error("fast power-down state wrong");

	a_full_pd_mode: assert property (
		pd_sync_ff && fr1_ff[FR1_PDMODE_BIT]
		|=> pll_pd && dac_bias_pd && osc_pd && clk_input_pd)
		else $error("full power-down incomplete");

	a_pin_overrides: assert property (
		pd_sync_ff && !fr1_ff[FR1_PDMODE_BIT] && fr1_ff[FR1_CLKPD_BIT]
		|=> !clk_input_pd)
		else $error("clock power-down bit honoured while pin high");

	a_pll_bypass_off: assert property (
		pll_bypass |=> pll_pd)
		else $error("bypassed pll left running");

	a_two_lvl_freq: assert property (
		level == LVL_2 && ramp_src == RAMP_OFF &&
		cfr_ff[0][CFR_TYPE_LSB +: 2] == MOD_FREQ
		|=> freq_word[0] == ($past(prof_sync_ff[0]) ?
			$past(prof_mem[1]) : $past(base_freq_ff[0])))
		else $error("two-level frequency selection wrong");

	a_ramp_pin_sense: assert property (
		level == LVL_8 && ramp_src == RAMP_P3 && pin_to_channel_config[1:0] == 2'h0 &&
		cfr_ff[0][CFR_TYPE_LSB +: 2] == MOD_FREQ
		|=> amplitude_ramp_active[0] &&
			amplitude_ramp_down[0] == $past(prof_sync_ff[3]))
		else $error("ramp pin sense wrong");

	a_sixteen_sel: assert property (
		level == LVL_16 && ramp_src == RAMP_OFF && pin_to_channel_config[1:0] == 2'h3 &&
		cfr_ff[3][CFR_TYPE_LSB +: 2] != MOD_OFF
		|-> route_w[3][5:2] == {prof_sync_ff[0], prof_sync_ff[1],
			prof_sync_ff[2], prof_sync_ff[3]} && !route_w[2][6])
		else $error("sixteen-level word index wrong");

endmodule // dcm_mode_ctrl

`default_nettype wire

// file: rtl/dcm_pkg.sv
// Constants for the channel mode control decode block
package dcm_pkg;

	localparam int CH_N = 4;
	localparam int FREQ_W = 32;
	localparam int PHASE_W = 14;
	localparam int AMP_W = 10;

	////////////////////////////////////////////////////////////////////
	// Register indices; byte address = {channel, index, 2'b00}
	localparam logic [5:0] FR1_IDX = 6'h01;
	localparam logic [5:0] CFR_IDX = 6'h03;
	localparam logic [5:0] FREQ0_IDX = 6'h04;
	localparam logic [5:0] PHASE0_IDX = 6'h05;
	localparam logic [5:0] AMP0_IDX = 6'h06;
	localparam logic [5:0] PROF_FIRST_IDX = 6'h0a;
	localparam logic [5:0] PROF_LAST_IDX = 6'h18;
	localparam logic [5:0] PROF_SLOT_BASE = 6'h09;
	localparam logic [5:0] STATUS_IDX = 6'h3e;
	localparam logic [5:0] SEL_IDX = 6'h3f;

	////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CFR_DIGPD_BIT = 6;
	localparam int CFR_DACPD_BIT = 7;
	localparam int CFR_SCALE_LSB = 8;
	localparam int CFR_SWEEP_BIT = 14;
	localparam int CFR_TYPE_LSB = 22;
	localparam int FR1_PDMODE_BIT = 6;
	localparam int FR1_CLKPD_BIT = 7;
	localparam int FR1_LEVEL_LSB = 8;
	localparam int FR1_RAMP_LSB = 10;
	localparam int FR1_PPC_LSB = 12;
	localparam int FR1_MULT_LSB = 18;

	////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] CFR_RST = 32'h0000_0300;
	localparam logic [31:0] FR1_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////
	// Encodings
	localparam logic [4:0] PLL_MULT_MIN = 5'h04;
	localparam logic [4:0] PLL_MULT_MAX = 5'h14;
	localparam logic [1:0] SCALE_FULL = 2'h3;
	localparam logic [1:0] SCALE_HALF = 2'h1;
	localparam logic [1:0] SCALE_QUARTER = 2'h2;
	localparam logic [1:0] SCALE_EIGHTH = 2'h0;
	localparam logic [1:0] MOD_OFF = 2'h0;
	localparam logic [1:0] MOD_AMP = 2'h1;
	localparam logic [1:0] MOD_FREQ = 2'h2;
	localparam logic [1:0] MOD_PHASE = 2'h3;
	localparam logic [1:0] LVL_2 = 2'h0;
	localparam logic [1:0] LVL_4 = 2'h1;
	localparam logic [1:0] LVL_8 = 2'h2;
	localparam logic [1:0] LVL_16 = 2'h3;
	localparam logic [1:0] RAMP_OFF = 2'h0;
	localparam logic [1:0] RAMP_P2P3 = 2'h1;
	localparam logic [1:0] RAMP_P3 = 2'h2;
	localparam logic [1:0] RAMP_SDIO = 2'h3;

endpackage

// file: test/dcm_ctrl_model.sv
// Behavioural controller model driving profile, spare and power-down pins
`timescale 1ns/1ps
`default_nettype none

module dcm_ctrl_model (
	input wire logic clk,
	output logic [3:0] profile_pin,
	output logic [2:0] spare_sdio,
	output logic external_powerdown_pin
);
	initial
	begin
		profile_pin = 4'h0;
		spare_sdio = 3'h0;
		external_powerdown_pin = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Pins change just after an edge; spare lines driven whatever the port width
	task automatic drive(input logic [3:0] p, input logic [2:0] s,
		input logic pd);
		@(posedge clk);
		profile_pin <= p;
		spare_sdio <= s;
		external_powerdown_pin <= pd;
	endtask
endmodule // dcm_ctrl_model

`default_nettype wire

// file: test/tb.sv
// Self-checking testbench for the channel mode control decode
`timescale 1ns/1ps
`default_nettype none

module tb
	import dcm_pkg::*;
();
	logic clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [9:0] avs_address;
	logic [3:0] avs_byteenable, profile_pin;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [2:0] spare_sdio;
	logic external_powerdown_pin, dac_bias_pd, pll_pd, osc_pd, clk_input_pd;
	logic serial_single_bit;
	logic [CH_N-1:0][FREQ_W-1:0] freq_word;
	logic [CH_N-1:0][PHASE_W-1:0] phase_word;
	logic [CH_N-1:0][AMP_W-1:0] amp_word;
	logic [CH_N-1:0][1:0] dac_atten;
	logic [CH_N-1:0] chan_digital_pd, chan_dac_pd;
	logic [CH_N-1:0] amplitude_ramp_active, amplitude_ramp_down;
	int n_errors = 0;
	int compares = 0;

	dcm_mode_ctrl dcm_mode_ctrl_i (.clk(clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .profile_pin(profile_pin),
		.spare_sdio(spare_sdio),
		.external_powerdown_pin(external_powerdown_pin),
		.freq_word(freq_word), .phase_word(phase_word),
		.amp_word(amp_word), .dac_atten(dac_atten),
		.chan_digital_pd(chan_digital_pd), .chan_dac_pd(chan_dac_pd),
		.dac_bias_pd(dac_bias_pd), .pll_pd(pll_pd), .osc_pd(osc_pd),
		.clk_input_pd(clk_input_pd),
		.amplitude_ramp_active(amplitude_ramp_active),
		.amplitude_ramp_down(amplitude_ramp_down),
		.serial_single_bit(serial_single_bit));

	dcm_ctrl_model dcm_ctrl_model_i (.clk(clk), .profile_pin(profile_pin),
		.spare_sdio(spare_sdio),
		.external_powerdown_pin(external_powerdown_pin));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Waits as long as the slave asks; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	function automatic logic [9:0] ra(input logic [1:0] ch,
		input logic [5:0] idx);
		return {ch, idx, 2'b00};
	endfunction

	// Multiplier 4 keeps the PLL in use
	function automatic logic [31:0] fr1(input logic [2:0] pin_to_channel_config,
		input logic [1:0] rmp, input logic [1:0] lvl, input logic [1:0] pd);
		return {9'h0, 5'h04, 3'h0, pin_to_channel_config, rmp, lvl, pd, 6'h0};
	endfunction

	function automatic logic [31:0] channel_function_register(input logic [1:0] typ,
		input logic [1:0] pd);
		return {8'h0, typ, 12'h0, SCALE_FULL, pd, 6'h0};
	endfunction

	task automatic settle;
		repeat (5) @(posedge clk);
	endtask

	task automatic tally_and_finish;
		$display("errors %0d, comparisons %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset_scale;
		logic [1:0] codes [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
		check(32'(dac_atten), 32'h0);
		check(32'(pll_pd), 32'h1);
		bus(1'b0, ra(2'h0, CFR_IDX), 32'h0);
		check(q, CFR_RST);
		bus(1'b0, ra(2'h0, 6'h02), 32'h0);
		check(q, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, ra(2'h0, CFR_IDX), {22'h0, codes[i], 8'h0});
			settle();
			check(32'(dac_atten[0]), i);
		end
		// Byte lanes: only the low byte may land
		avs_byteenable <= 4'h1;
		bus(1'b1, ra(2'h1, FREQ0_IDX), 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		bus(1'b0, ra(2'h1, FREQ0_IDX), 32'h0);
		check(q, 32'h0000_00ff);
	endtask

	task automatic t_power;
		bus(1'b1, ra(2'h0, FR1_IDX), {9'h0, 5'h15, 18'h0});
		settle();
		check(32'(pll_pd), 32'h1);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h0, 2'h0, 2'h0, 2'b10));
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_OFF, 2'b01));
		settle();
		check(32'({pll_pd, clk_input_pd}), 32'h1);
		check(32'({chan_dac_pd, chan_digital_pd}),
			32'h02);
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_OFF, 2'b10));
		settle();
		check(32'({chan_dac_pd, chan_digital_pd}), 32'h20);
		dcm_ctrl_model_i.drive(4'h0, 3'h0, 1'b1);
		settle();
		check(32'({chan_dac_pd, chan_digital_pd}),
			32'hff);
		check(32'({dac_bias_pd, pll_pd, osc_pd, clk_input_pd}),
			32'h0);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h0, 2'h0, 2'h0, 2'b11));
		settle();
		check(32'({dac_bias_pd, pll_pd, osc_pd, clk_input_pd}),
			32'hf);
		dcm_ctrl_model_i.drive(4'h0, 3'h0, 1'b0);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h0, 2'h0, 2'h0, 2'b00));
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_OFF, 2'b00));
		settle();
		check(32'({chan_dac_pd, chan_digital_pd, pll_pd, clk_input_pd}),
			32'h0);
	endtask

	task automatic t_two_level;
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h5, RAMP_OFF, LVL_2, 2'b00));
		bus(1'b1, ra(2'h0, CFR_IDX), channel_function_register(MOD_FREQ, 2'b00));
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_PHASE, 2'b00));
		bus(1'b1, ra(2'h2, CFR_IDX), channel_function_register(MOD_AMP, 2'b00));
		bus(1'b1, ra(2'h0, FREQ0_IDX), 32'h1111_1111);
		bus(1'b1, ra(2'h0, PROF_FIRST_IDX), 32'h2222_2222);
		bus(1'b1, ra(2'h1, PHASE0_IDX), 32'h0000_1234);
		bus(1'b1, ra(2'h1, PROF_FIRST_IDX), 32'habcd_ffff);
		bus(1'b1, ra(2'h2, PROF_FIRST_IDX), 32'hc0ff_eeee);
		dcm_ctrl_model_i.drive(4'h7, 3'h0, 1'b0);
		settle();
		check(freq_word[0], 32'h2222_2222);
		check(32'(phase_word[1]), 32'h2af3);
		check(32'(amp_word[2]), 32'h303);
		dcm_ctrl_model_i.drive(4'h0, 3'h0, 1'b0);
		settle();
		check(freq_word[0], 32'h1111_1111);
		check(32'(phase_word[1]), 32'h1234);
	endtask

	task automatic t_sixteen;
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h3, RAMP_OFF, LVL_16, 2'b00));
		for (int c = 0; c < 3; c++)
			bus(1'b1, ra(c[1:0], CFR_IDX), channel_function_register(MOD_OFF, 2'b00));
		bus(1'b1, ra(2'h3, CFR_IDX), channel_function_register(MOD_FREQ, 2'b00));
		bus(1'b1, ra(2'h3, 6'h17), 32'h5a5a_0e0e);
		bus(1'b1, ra(2'h3, PROF_LAST_IDX), 32'h0f0f_1818);
		dcm_ctrl_model_i.drive(4'b0111, 3'h0, 1'b0);
		settle();
		check(freq_word[3], 32'h5a5a_0e0e);
		dcm_ctrl_model_i.drive(4'b1111, 3'h0, 1'b0);
		settle();
		check(freq_word[3], 32'h0f0f_1818);
	endtask

	task automatic t_ramp;
		bus(1'b1, ra(2'h0, CFR_IDX), channel_function_register(MOD_FREQ, 2'b00));
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_PHASE, 2'b00));
		bus(1'b1, ra(2'h2, CFR_IDX), channel_function_register(MOD_AMP, 2'b00));
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h0, RAMP_SDIO, LVL_2, 2'b00));
		dcm_ctrl_model_i.drive(4'h0, 3'b111, 1'b0);
		settle();
		check(32'(serial_single_bit), 32'h1);
		check(32'(amplitude_ramp_active), 32'h3);
		check(32'(amplitude_ramp_down[0]), 32'h1);
		check(freq_word[0], 32'h1111_1111);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h0, RAMP_P2P3, LVL_2, 2'b00));
		dcm_ctrl_model_i.drive(4'b1000, 3'h0, 1'b0);
		settle();
		check(32'(serial_single_bit), 32'h0);
		check(32'(amplitude_ramp_active[1:0]), 32'h3);
		check(32'(amplitude_ramp_down[1:0]), 32'h2);
	endtask

	// Four-level on channels 0 and 3, then eight-level with pin 3 ramp
	task automatic t_multi;
		bus(1'b1, ra(2'h1, CFR_IDX), channel_function_register(MOD_OFF, 2'b00));
		bus(1'b1, ra(2'h2, CFR_IDX), channel_function_register(MOD_OFF, 2'b00));
		bus(1'b1, ra(2'h0, 6'h0c), 32'h4444_4444);
		bus(1'b1, ra(2'h3, PROF_FIRST_IDX), 32'h3333_3333);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h2, RAMP_OFF, LVL_4, 2'b00));
		dcm_ctrl_model_i.drive(4'b1011, 3'h0, 1'b0);
		settle();
		check(freq_word[0], 32'h4444_4444);
		check(freq_word[3], 32'h3333_3333);
		bus(1'b1, ra(2'h3, CFR_IDX), channel_function_register(MOD_OFF, 2'b00));
		bus(1'b1, ra(2'h0, 6'h0e), 32'h5555_5555);
		bus(1'b1, ra(2'h0, FR1_IDX), fr1(3'h4, RAMP_P3, LVL_8, 2'b00));
		dcm_ctrl_model_i.drive(4'b1101, 3'h0, 1'b0);
		settle();
		check(freq_word[0], 32'h5555_5555);
		check(32'(amplitude_ramp_active), 32'h1);
		check(32'(amplitude_ramp_down), 32'h1);
		bus(1'b0, ra(2'h0, SEL_IDX), 32'h0);
		check(q, 32'h0000_0057);
		bus(1'b0, ra(2'h0, STATUS_IDX), 32'h0);
		check(q, 32'h0000_000d);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial
	begin
		rst = 1'b1;
		avs_address = 10'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset_scale();
		t_power();
		t_two_level();
		t_sixteen();
		t_ramp();
		t_multi();
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		tally_and_finish();
	end
endmodule // tb

`default_nettype wire
